//--- hw/dsc_pkg.sv
package dsc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0]  GEN_STATUS_OFS = 8'h90;
   localparam logic [7:0]  INT_CAUSE_OFS  = 8'h98;

   ////////////////////////////////////////////////////////////////////////////////
   // Device state codes
   localparam logic [1:0]  DS_DISABLED = 2'h0;
   localparam logic [1:0]  DS_ENABLED  = 2'h1;
   localparam logic [1:0]  DS_BUSY     = 2'h2;
   localparam logic [1:0]  DS_HALTED   = 2'h3;

   // Required reset codes
   localparam logic [1:0]  RR_SW_CMD = 2'h0;
   localparam logic [1:0]  RR_FLR    = 2'h1;
   localparam logic [1:0]  RR_WARM   = 2'h2;
   localparam logic [1:0]  RR_COLD   = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // Cause bit positions
   localparam int          CB_SW_ERR  = 0;
   localparam int          CB_CMD     = 1;
   localparam int          CB_OCC     = 2;
   localparam int          CB_PERF    = 3;
   localparam int          CB_HALT    = 4;
   localparam int          CB_EVLOG   = 5;
   localparam int          CB_REVOKED = 31;
   localparam logic [31:0] CAUSE_MASK = 32'h8000003f;
   localparam logic [31:0] CAUSE_RST  = 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////////
   // Command codes
   localparam logic [4:0]  CMD_ENABLE  = 5'h01;
   localparam logic [4:0]  CMD_DISABLE = 5'h02;
   localparam logic [4:0]  CMD_RESET   = 5'h05;

   ////////////////////////////////////////////////////////////////////////////////
   // Quiesce time
   localparam int          CLK_PERIOD_NS = 20;
   localparam int          DRAIN_TIME_NS = 100;
   localparam int          DRAIN_CYCLES  = (DRAIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0]  DRAIN_LOAD    = 3'(DRAIN_CYCLES - 1);

   typedef enum logic [1:0] {ST_DISABLED, ST_ENABLED, ST_QUIESCE, ST_HALTED} dsc_state_t;

   // State to register code
   function automatic logic [1:0] dsc_code(input dsc_state_t s);
      case (s)
         ST_DISABLED: dsc_code = DS_DISABLED;
         ST_ENABLED:  dsc_code = DS_ENABLED;
         ST_QUIESCE:  dsc_code = DS_BUSY;
         ST_HALTED:   dsc_code = DS_HALTED;
         default:     dsc_code = DS_DISABLED;
      endcase
   endfunction

endpackage

//--- hw/dsc_stat_if.sv
`timescale 1ns/1ps
interface dsc_stat_if;
   logic [1:0] dev_state;
   logic [1:0] reset_type;
   logic       cmd_done;
   logic       cmd_irq;
   logic       halt_enter;

   modport fsm  (output dev_state, reset_type, cmd_done, cmd_irq, halt_enter);
   modport regs (input  dev_state, reset_type, cmd_done, cmd_irq, halt_enter);
endinterface

//--- hw/dsc_dev_fsm.sv
`timescale 1ns/1ps
module dsc_dev_fsm
   import dsc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Commands
   input  wire logic       cmd_valid,
   input  wire logic [4:0] cmd_code,
   input  wire logic       cmd_irq_req,
   // Halt events
   input  wire logic       halt_err,
   input  wire logic [1:0] halt_rst_type,
   // Status toward the register bank
   dsc_stat_if.fsm         st
);

   dsc_state_t state_q, state_d;
   logic [2:0] cnt_q;
   logic [1:0] type_q;
   logic       irq_pend_q;
   logic       done_q;
   logic       cmd_irq_q;
   logic       halt_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode
   wire logic busy_w     = (state_q == ST_QUIESCE);
   wire logic take_w     = cmd_valid && !busy_w;
   wire logic is_en_w    = take_w && (cmd_code == CMD_ENABLE) && (state_q == ST_DISABLED);
   wire logic is_dis_w   = take_w && (cmd_code == CMD_DISABLE) && (state_q == ST_ENABLED);
   wire logic is_rst_w   = take_w && (cmd_code == CMD_RESET) &&
                           ((state_q != ST_HALTED) || (type_q == RR_SW_CMD));
   wire logic go_q_w     = is_dis_w || is_rst_w;
   wire logic drain_end  = busy_w && (cnt_q == 3'h0);
   wire logic done_w     = (take_w && !go_q_w) || (busy_w && (drain_end || halt_err));
   wire logic irq_w      = done_w && (busy_w ? irq_pend_q : cmd_irq_req);
   wire logic[1:0] typ_w = (halt_rst_type > type_q) ? halt_rst_type : type_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_DISABLED: begin
            if (is_en_w) state_d = ST_ENABLED;
            else if (go_q_w) state_d = ST_QUIESCE;
         end
         ST_ENABLED: begin
            if (go_q_w) state_d = ST_QUIESCE;
         end
         ST_QUIESCE: begin
            if (drain_end) state_d = ST_DISABLED;
         end
         ST_HALTED: begin
            if (go_q_w) state_d = ST_QUIESCE;
         end
         default: state_d = ST_DISABLED;
      endcase
      if (halt_err) state_d = ST_HALTED;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= ST_DISABLED;
         cnt_q      <= 3'h0;
         type_q     <= RR_SW_CMD;
         irq_pend_q <= 1'b0;
         done_q     <= 1'b0;
         cmd_irq_q  <= 1'b0;
         halt_q     <= 1'b0;
      end else begin
         state_q    <= state_d;
         cnt_q      <= go_q_w ? DRAIN_LOAD : (busy_w ? cnt_q - 3'h1 : cnt_q);
         type_q     <= halt_err ? typ_w : (is_rst_w ? RR_SW_CMD : type_q);
         irq_pend_q <= go_q_w ? cmd_irq_req : irq_pend_q;
         done_q     <= done_w;
         cmd_irq_q  <= irq_w;
         halt_q     <= halt_err && (state_q != ST_HALTED);
      end
   end

   assign st.reset_type = type_q;
   assign st.dev_state  = dsc_code(state_q);
   assign st.cmd_done   = done_q;
   assign st.cmd_irq    = cmd_irq_q;
   assign st.halt_enter = halt_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   drain_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_q == ST_QUIESCE |-> ##[1:5] state_q != ST_QUIESCE)
      else $error("Quiesce did not end in time");
   reset_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
      is_rst_w && !halt_err |=> state_q == ST_QUIESCE ##[1:5]
      (state_q == ST_DISABLED || state_q == ST_HALTED))
      else $error("Reset command did not disable the device");
   rst_type_a: assert property (@(posedge clk) disable iff (!rst_n)
      halt_err |=> type_q >= $past(halt_rst_type) && state_q == ST_HALTED)
      else $error("Reset type weaker than reported halt");

endmodule

//--- hw/dsc_status_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Disabled reads 00, submissions get retry
// - Enabled reads 01, submissions accepted
// - Disabling or resetting reads 10, refuses submissions
// - Halt reads 11 until proper reset
// - Reset type codes: command, FLR, warm, cold
// - Bits 3:2 give weakest recovering reset
// - Status register read only, bits 31:4 zero
// - Cause register covers entry-0 interrupt only
// - No cause register for other vectors
// - Seven write-one-to-clear cause flags at fixed bits
// - Halt with enable sets flag, interrupts
// - Error log valid rise sets flag, interrupts
// - Command completion interrupt sets flag
// - Reset command disables, clears, recovers 00; ignored when halted with reset type above command
module dsc_status_regs
   import dsc_pkg::*;
(
   // Clock and reset
   input  wire  logic        REF_CLK,
   input  wire  logic        NRST,
   // Register access
   input  wire  logic [7:0]  REG_ADDR,
   input  wire  logic        REG_RD,
   input  wire  logic        REG_WR,
   input  wire  logic [31:0] REG_WDATA,
   output logic       [31:0] REG_RDATA,
   output logic              REG_RVALID,
   // Commands
   input  wire  logic        CMD_VALID,
   input  wire  logic [4:0]  CMD_CODE,
   input  wire  logic        CMD_IRQ_REQ,
   output logic              CMD_DONE,
   // Interrupt enables from general_control
   input  wire  logic        SWERR_IRQ_EN,
   input  wire  logic        HALT_IRQ_EN,
   input  wire  logic        EVLOG_IRQ_EN,
   // Events
   input  wire  logic        SWERR_VALID,
   input  wire  logic        HALT_ERR,
   input  wire  logic [1:0]  HALT_RST_TYPE,
   input  wire  logic        OCC_BELOW_EVT,
   input  wire  logic        PERF_OVF_EVT,
   input  wire  logic        EVLOG_EVT,
   input  wire  logic        REVOKE_EVT,
   // Work queue side
   input  wire  logic        SUBMIT_REQ,
   output logic              SUBMIT_ACCEPT,
   output logic              SUBMIT_RETRY,
   output logic              WQ_ENABLE_OK,
   // Status
   output logic       [1:0]  DEV_STATE,
   output logic              IRQ0
);

   dsc_stat_if st_if ();

   logic [31:0] cause_q;
   logic        swerr_q;
   logic [31:0] rdata_q;
   logic        rvalid_q;
   logic        done_q;
   logic        accept_q;
   logic        retry_q;
   logic        wq_ok_q;
   logic [1:0]  state_q;
   logic        irq_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Device state machine
   dsc_dev_fsm u_fsm (
      .clk           (REF_CLK),
      .rst_n         (NRST),
      .cmd_valid     (CMD_VALID),
      .cmd_code      (CMD_CODE),
      .cmd_irq_req   (CMD_IRQ_REQ),
      .halt_err      (HALT_ERR),
      .halt_rst_type (HALT_RST_TYPE),
      .st            (st_if.fsm)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Decode
   wire logic        sel_stat_w = (REG_ADDR == GEN_STATUS_OFS);
   wire logic        sel_caus_w = (REG_ADDR == INT_CAUSE_OFS);
   wire logic        enabled_w  = (st_if.dev_state == DS_ENABLED);
   wire logic        swerr_rise = SWERR_VALID && !swerr_q;
   // status read only, upper bits zero
   wire logic [31:0] stat_w     = {28'h0, st_if.reset_type, st_if.dev_state};
   wire logic [31:0] rd_mux_w   = sel_stat_w ? stat_w : (sel_caus_w ? cause_q : 32'h0);

   wire logic [31:0] set_w = {REVOKE_EVT, 25'h0,
                              EVLOG_EVT && EVLOG_IRQ_EN,
                              st_if.halt_enter && HALT_IRQ_EN,
                              PERF_OVF_EVT,
                              OCC_BELOW_EVT,
                              st_if.cmd_irq,
                              swerr_rise && SWERR_IRQ_EN};
   wire logic [31:0] clr_w   = (REG_WR && sel_caus_w) ? (REG_WDATA & CAUSE_MASK) : 32'h0;
   wire logic [31:0] cause_d = ((cause_q & ~clr_w) | set_w) & CAUSE_MASK;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         cause_q  <= CAUSE_RST;
         swerr_q  <= 1'b0;
         rdata_q  <= 32'h0;
         rvalid_q <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         cause_q  <= cause_d;
         swerr_q  <= SWERR_VALID;
         rdata_q  <= REG_RD ? rd_mux_w : rdata_q;
         rvalid_q <= REG_RD;
         irq_q    <= |set_w;
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         done_q   <= 1'b0;
         accept_q <= 1'b0;
         retry_q  <= 1'b0;
         wq_ok_q  <= 1'b0;
         state_q  <= DS_DISABLED;
      end else begin
         done_q   <= st_if.cmd_done;
         accept_q <= SUBMIT_REQ && enabled_w;
         retry_q  <= SUBMIT_REQ && !enabled_w;
         wq_ok_q  <= enabled_w;
         state_q  <= st_if.dev_state;
      end
   end

   assign REG_RDATA     = rdata_q;
   assign REG_RVALID    = rvalid_q;
   assign CMD_DONE      = done_q;
   assign SUBMIT_ACCEPT = accept_q;
   assign SUBMIT_RETRY  = retry_q;
   assign WQ_ENABLE_OK  = wq_ok_q;
   assign DEV_STATE     = state_q;
   assign IRQ0          = irq_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking dc @(posedge REF_CLK); endclocking
   default disable iff (!NRST);

   stat_upper_a: assert property (REG_RD && sel_stat_w |=> REG_RDATA[31:4] == 28'h0)
      else $error("Status upper bits not zero");
   rsvd_zero_a: assert property (cause_q[30:6] == 25'h0)
      else $error("Reserved cause bits set");
   w1c_hold_a: assert property (REG_WR && sel_caus_w && !REG_WDATA[0] && cause_q[0]
      |=> cause_q[0])
      else $error("Writing zero cleared a cause flag");
   w1c_clear_a: assert property (REG_WR && sel_caus_w && REG_WDATA[1] && !set_w[1]
      |=> !cause_q[1])
      else $error("Write one did not clear flag");
   dis_retry_a: assert property (SUBMIT_REQ && st_if.dev_state == DS_DISABLED
      |=> SUBMIT_RETRY && !SUBMIT_ACCEPT)
      else $error("Disabled device did not retry");
   en_accept_a: assert property (SUBMIT_REQ && st_if.dev_state == DS_ENABLED
      |=> SUBMIT_ACCEPT && !SUBMIT_RETRY && WQ_ENABLE_OK)
      else $error("Enabled device refused submission");
   busy_refuse_a: assert property (SUBMIT_REQ && st_if.dev_state == DS_BUSY
      |=> !SUBMIT_ACCEPT)
      else $error("Busy device accepted submission");
   halt_hold_a: assert property (st_if.dev_state == DS_HALTED
      && !(CMD_VALID && CMD_CODE == CMD_RESET) |=> st_if.dev_state == DS_HALTED)
      else $error("Halted state left without reset");
   halt_cause_a: assert property (st_if.halt_enter && HALT_IRQ_EN
      |=> cause_q[CB_HALT] && IRQ0)
      else $error("Halt did not set cause and interrupt");
   swerr_cause_a: assert property (SWERR_VALID && !swerr_q && SWERR_IRQ_EN
      |=> cause_q[CB_SW_ERR] && IRQ0)
      else $error("Error log rise missed");
   cmd_cause_a: assert property (st_if.cmd_irq |=> cause_q[CB_CMD] && IRQ0 ##1 1'b1)
      else $error("Command completion cause missed");
   irq_cause_a: assert property (IRQ0 |-> cause_q != 32'h0)
      else $error("Interrupt without a cause");

   rd_valid_a: assert property (REG_RD |=> REG_RVALID)
      else $error("Read not answered");
   stat_ro_a: assert property (REG_WR && sel_stat_w && !CMD_VALID && !HALT_ERR
      && st_if.dev_state != DS_BUSY |=> $stable(st_if.dev_state) && $stable(st_if.reset_type))
      else $error("Status write changed the status");
   unmapped_zero_a: assert property (REG_RD && !sel_stat_w && !sel_caus_w
      |=> REG_RDATA == 32'h0)
      else $error("Unmapped read not zero");
   one_answer_a: assert property (!(SUBMIT_ACCEPT && SUBMIT_RETRY))
      else $error("Submission both accepted and retried");
   wq_ok_a: assert property (st_if.dev_state == DS_ENABLED |=> WQ_ENABLE_OK)
      else $error("Enabled device blocked queue enable");
   busy_retry_a: assert property (SUBMIT_REQ && st_if.dev_state == DS_BUSY
      |=> SUBMIT_RETRY)
      else $error("Busy device gave no retry");
   halt_code_a: assert property (HALT_ERR |-> ##2 DEV_STATE == DS_HALTED)
      else $error("Halt not reported");
   rtype_field_a: assert property (REG_RD && sel_stat_w
      |=> REG_RDATA[3:2] == $past(st_if.reset_type))
      else $error("Reset type field not reported");
   evlog_gate_a: assert property (EVLOG_EVT && !EVLOG_IRQ_EN && !cause_q[CB_EVLOG]
      |=> !cause_q[CB_EVLOG])
      else $error("Gated event log set its flag");

   halt_seen_c: cover property (st_if.dev_state == DS_HALTED ##[1:20] st_if.dev_state == DS_BUSY);
   cmd_irq_c:   cover property (st_if.cmd_irq ##[1:10] REG_WR && sel_caus_w);
   accept_c:    cover property (SUBMIT_ACCEPT);
   retry_c:     cover property (SUBMIT_RETRY);
   w1c_c:       cover property (REG_WR && sel_caus_w && (REG_WDATA & cause_q) != 32'h0);

endmodule

//--- verif/device_status_and_irq_cause_regs_tb.sv
`timescale 1ns/1ps
module device_status_and_irq_cause_regs_tb;
   import dsc_pkg::*;
   logic        clk    = 1'b0;
   logic        nrst   = 1'b0;
   logic [7:0]  addr   = 8'h00;
   logic        rd     = 1'b0;
   logic        wr     = 1'b0;
   logic [31:0] wdata  = 32'h0;
   logic        cvalid = 1'b0;
   logic [4:0]  ccode  = 5'h00;
   logic        cirq   = 1'b0;
   logic        sw_en  = 1'b0;
   logic        h_en   = 1'b0;
   logic        ev_en  = 1'b0;
   logic        swv    = 1'b0;
   logic        herr   = 1'b0;
   logic [1:0]  htype  = 2'h0;
   logic [3:0]  evt    = 4'h0;
   logic        sub    = 1'b0;
   logic [31:0] rdata;
   logic        rvalid;
   logic        done;
   logic        acc;
   logic        rty;
   logic        wq_ok;
   logic [1:0]  dstate;
   logic        irq0;
   int          n_mismatch = 0;
   int          compares = 0;
   int          seed = 58393;
   int          cause_m;
   int          state_m;
   int          rtype_m;
   int          i;
   int          k;

   always #10 clk = ~clk;

   dsc_status_regs dut (
      .REF_CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_RD(rd), .REG_WR(wr),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .CMD_VALID(cvalid), .CMD_CODE(ccode), .CMD_IRQ_REQ(cirq), .CMD_DONE(done),
      .SWERR_IRQ_EN(sw_en), .HALT_IRQ_EN(h_en), .EVLOG_IRQ_EN(ev_en),
      .SWERR_VALID(swv), .HALT_ERR(herr), .HALT_RST_TYPE(htype),
      .OCC_BELOW_EVT(evt[0]), .PERF_OVF_EVT(evt[1]), .EVLOG_EVT(evt[2]),
      .REVOKE_EVT(evt[3]), .SUBMIT_REQ(sub), .SUBMIT_ACCEPT(acc),
      .SUBMIT_RETRY(rty), .WQ_ENABLE_OK(wq_ok), .DEV_STATE(dstate), .IRQ0(irq0)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task summarize;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task do_reset;
      @(posedge clk);
      nrst <= 1'b0;
      swv <= 1'b0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      cause_m = 0;
      state_m = 0;
      rtype_m = 0;
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("read valid", 32'(rvalid), 32'h1);
      chk("read data", rdata, exp);
   endtask

   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr <= 1'b1;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      if (a == INT_CAUSE_OFS) cause_m = cause_m & ~(d & CAUSE_MASK);
   endtask

   task submit(input logic ok);
      @(posedge clk);
      sub <= 1'b1;
      @(posedge clk);
      sub <= 1'b0;
      #1 chk("accept", 32'(acc), 32'(ok));
      chk("retry", 32'(rty), 32'(!ok));
      chk("wq enable", 32'(wq_ok), 32'(ok));
   endtask

   task cmd(input logic [4:0] c, input logic ir);
      logic bz;
      bz = (c == CMD_DISABLE && state_m == 1) ||
           (c == CMD_RESET && !(state_m == 3 && rtype_m != 0));
      @(posedge clk);
      ccode <= c;
      cirq <= ir;
      cvalid <= 1'b1;
      @(posedge clk);
      cvalid <= 1'b0;
      #1 i = 0;
      while (done !== 1'b1 && i < 20) begin
         @(posedge clk);
         sub <= bz && i == 0;
         #1 i++;
         if (bz && i == 1) chk("busy state", 32'(dstate), 32'(DS_BUSY));
         if (bz && i == 2) chk("busy retry", 32'(rty), 32'h1);
      end
      chk("done latency", 32'(i), bz ? 32'(DRAIN_CYCLES + 1) : 32'h1);
      if (done !== 1'b1) summarize();
      chk("completion irq", 32'(irq0), 32'(ir));
      if (c == CMD_ENABLE) state_m = 1;
      if (bz) state_m = 0;
      if (bz && c == CMD_RESET) rtype_m = 0;
      if (ir) cause_m = cause_m | 2;
      rd_chk(GEN_STATUS_OFS, 32'(rtype_m * 4 + state_m));
      rd_chk(INT_CAUSE_OFS, cause_m);
   endtask

   task event_in(input logic [3:0] e, input logic s, input int bits, input logic ir);
      @(posedge clk);
      evt <= e;
      swv <= s;
      @(posedge clk);
      evt <= 4'h0;
      #1 chk("event irq", 32'(irq0), 32'(ir));
      cause_m = cause_m | bits;
      rd_chk(INT_CAUSE_OFS, cause_m);
   endtask

   task halt(input logic [1:0] t);
      @(posedge clk);
      herr <= 1'b1;
      htype <= t;
      @(posedge clk);
      herr <= 1'b0;
      @(posedge clk);
      #1 chk("halt irq", 32'(irq0), 32'(h_en));
      chk("halt state", 32'(dstate), 32'(DS_HALTED));
      if (h_en) cause_m = cause_m | 32'h10;
      if (t > rtype_m) rtype_m = t;
      state_m = 3;
      rd_chk(GEN_STATUS_OFS, 32'(rtype_m * 4 + 3));
      rd_chk(INT_CAUSE_OFS, cause_m);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      do_reset();
      rd_chk(GEN_STATUS_OFS, 32'h0);
      rd_chk(INT_CAUSE_OFS, 32'h0);
      submit(1'b0);
      $display("test reset values done");
      cmd(CMD_ENABLE, 1'b1);
      submit(1'b1);
      wr_reg(INT_CAUSE_OFS, 32'h0);
      rd_chk(INT_CAUSE_OFS, cause_m);
      wr_reg(INT_CAUSE_OFS, 32'h7ffffffd);
      rd_chk(INT_CAUSE_OFS, cause_m);
      wr_reg(GEN_STATUS_OFS, $random(seed));
      rd_chk(GEN_STATUS_OFS, 32'h1);
      rd_chk(8'h94, 32'h0);
      $display("test enable and access done");
      ev_en <= 1'b0;
      event_in(4'h4, 1'b0, 0, 1'b0);
      ev_en <= 1'b1;
      sw_en <= 1'b1;
      event_in(4'h1, 1'b0, 32'h4, 1'b1);
      event_in(4'h2, 1'b0, 32'h8, 1'b1);
      event_in(4'h4, 1'b0, 32'h20, 1'b1);
      event_in(4'h8, 1'b0, 32'h80000000, 1'b1);
      event_in(4'h0, 1'b1, 32'h1, 1'b1);
      for (k = 0; k < 4; k++) begin
         wr_reg(INT_CAUSE_OFS, $random(seed));
         rd_chk(INT_CAUSE_OFS, cause_m);
      end
      wr_reg(INT_CAUSE_OFS, 32'hffffffff);
      rd_chk(INT_CAUSE_OFS, 32'h0);
      $display("test cause flags done");
      cmd(CMD_DISABLE, 1'b0);
      submit(1'b0);
      $display("test disable done");
      for (k = 0; k < 4; k++) begin
         do_reset();
         h_en <= k[0];
         halt(2'(k));
         submit(1'b0);
         cmd(CMD_RESET, 1'b1);
      end
      do_reset();
      cmd(CMD_ENABLE, 1'b0);
      halt(2'h0);
      cmd(CMD_RESET, 1'b0);
      $display("test halt and recovery done");
      summarize();
   end
endmodule
